// *** pfw_core.sv ***
// program flash self-write path: table access, write latches, row commit
//
// Behaviour
// - low-half table read/write reaches bits 15..0, word or byte mode
// - high-half table read/write reaches bits 23..16 in word mode or even byte mode; odd byte mode reads 0 and writes nothing
// - address is page bits 7..0 above the 16-bit effective address
// - rows hold 32 instructions (96 bytes); an erase clears exactly one row
// - each panel holds 128 rows, 4K words of 24 bits
// - a whole row of 32 instructions is programmed at once, each needing low and high writes
// - one set of 32 write latches shared by all panels, filled before programming starts
// - a table write takes two cycles and only touches the latches
// - latches reach flash only when a started cycle commits one row
// - serial port uses exactly two lines: clock from programmer, and data
// - start bit begins the operation, stalls 2 ms, then self-clears
// - address registers capture last table address and select the row
`timescale 1ns/100ps
`default_nettype none
`include "pfw_defs.svh"
module pfw_core #(
  parameter int MEM_WORDS  = `PFW_MEM_WORDS,
  parameter int OP_CYCLES  = `PFW_OP_CYCLES,
  parameter int FIFO_DEPTH = `PFW_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      sys_rst_i,
  // table operation requests from the core
  input  wire logic                      req_valid_i,
  output logic                           req_ready_o,
  input  wire pfw_pkg::pfw_req_t         req_i,
  // read answers
  output logic                           rd_valid_o,
  output logic [15:0]                    rd_data_o,
  // status
  output logic                           core_stall_o,
  output logic                           write_start_o,
  output logic [`PFW_ADDR_W-1:0]         flash_address_o,
  output logic                           key_unlocked_o,
  // serial programming port lines
  input  wire logic                      prog_clock_line_i,
  input  wire logic                      prog_data_line_i,
  output logic                           prog_data_line_o,
  output logic                           prog_data_line_oe_o
);
  import pfw_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  initial begin
    if (MEM_WORDS % `PFW_PANEL_WORDS != 0 || MEM_WORDS > (1 << 23))
      $error("memory must be whole panels within the address space");
    // the commit walks one latch per cycle, so a shorter op leaves the row half written
    if (OP_CYCLES < `PFW_ROW_WORDS) $error("operation time must cover a whole row commit");
  end

  // ----------------------------------------------------------------
  // request buffering
  // ----------------------------------------------------------------
  pfw_req_t   q_req;
  logic       q_valid;
  logic       q_ready;

  pfw_fifo #(
    .WIDTH ($bits(pfw_req_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   (req_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_ready),
    .out_data_o  (q_req)
  );

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [`PFW_WORD_W-1:0] flash_mem [MEM_WORDS];
  logic [`PFW_WORD_W-1:0] latch_mem [`PFW_ROW_WORDS];

  pfw_state_t             state;
  logic [31:0]            op_cnt;
  logic [`PFW_ADDR_W-1:0] full_addr;
  logic [4:0]             slot;
  logic [AW-1:0]          word_idx;
  logic [AW-1:0]          row_base;
  logic                   take;
  logic                   key_half;
  logic                   erase_op;
  logic [5:0]             commit_idx;

  assign full_addr = {q_req.page, q_req.ea};
  assign slot      = full_addr[5:1];
  assign word_idx  = full_addr[AW:1];
  assign row_base  = {flash_address_o[AW:6], 5'h00};

  // a table write is held a second cycle, the other ops pass in one
  assign q_ready = (state == PFW_ST_IDLE) && q_valid &&
                   !((q_req.op == PFW_OP_WRITE_LOW || q_req.op == PFW_OP_WRITE_HIGH) && op_cnt == 32'h0);
  assign take    = q_ready;
  assign core_stall_o  = (state == PFW_ST_BUSY);
  assign write_start_o = (state == PFW_ST_BUSY);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state      <= PFW_ST_IDLE;
      op_cnt     <= 32'h0;
      commit_idx <= 6'h00;
      erase_op   <= 1'b0;
    end else begin
      case (state)
        PFW_ST_IDLE: begin
          if (q_valid && !take && op_cnt == 32'h0) begin
            op_cnt <= 32'h1;
          end else if (take) begin
            op_cnt <= 32'h0;
          end
          if (take && q_req.op == PFW_OP_START && key_unlocked_o) begin
            state      <= PFW_ST_BUSY;
            op_cnt     <= 32'h0;
            commit_idx <= 6'h00;
            erase_op   <= q_req.erase;
          end
        end
        PFW_ST_BUSY: begin
          if (commit_idx < 6'(`PFW_ROW_WORDS)) begin
            commit_idx <= commit_idx + 6'h01;
          end
          if (op_cnt >= 32'(OP_CYCLES - 1)) begin
            state  <= PFW_ST_IDLE;
            op_cnt <= 32'h0;
          end else begin
            op_cnt <= op_cnt + 32'h1;
          end
        end
        default: begin
          state <= PFW_ST_IDLE;
        end
      endcase
    end
  end

  // unlock: 0x55 then 0xaa on consecutive key ops, consumed by a start
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      key_half       <= 1'b0;
      key_unlocked_o <= 1'b0;
    end else if (take) begin
      key_half       <= (q_req.op == PFW_OP_KEY) && (q_req.data[7:0] == `PFW_KEY_FIRST);
      key_unlocked_o <= (q_req.op == PFW_OP_KEY) && key_half &&
                        (q_req.data[7:0] == `PFW_KEY_SECOND);
    end
  end

  // address capture of the last table operation
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_address_o <= '0;
    end else if (take && q_req.op != PFW_OP_KEY && q_req.op != PFW_OP_START) begin
      flash_address_o <= full_addr;
    end
  end

  // write latches: only table writes load them, only commit drains them
  always_ff @(posedge core_clk_i) begin
    if (take && q_req.op == PFW_OP_WRITE_LOW) begin
      if (!q_req.byte_mode) begin
        latch_mem[slot][15:0] <= q_req.data;
      end else if (q_req.ea[0]) begin
        latch_mem[slot][15:8] <= q_req.data[7:0];
      end else begin
        latch_mem[slot][7:0] <= q_req.data[7:0];
      end
    end
    if (take && q_req.op == PFW_OP_WRITE_HIGH && !(q_req.byte_mode && q_req.ea[0])) begin
      latch_mem[slot][23:16] <= q_req.data[7:0];
    end
  end

  // flash array: touched only during a started cycle, one row per cycle
  always_ff @(posedge core_clk_i) begin
    if (state == PFW_ST_BUSY && commit_idx < 6'(`PFW_ROW_WORDS)) begin
      if (erase_op) begin
        flash_mem[row_base + AW'(commit_idx)] <= `PFW_ERASED_WORD;
      end else begin
        flash_mem[row_base + AW'(commit_idx)] <= latch_mem[commit_idx[4:0]];
      end
    end
  end

  // table reads
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= 16'h0000;
    end else begin
      rd_valid_o <= take && (q_req.op == PFW_OP_READ_LOW || q_req.op == PFW_OP_READ_HIGH);
      if (take && q_req.op == PFW_OP_READ_LOW) begin
        if (q_req.byte_mode) begin
          rd_data_o <= {8'h00, q_req.ea[0] ? flash_mem[word_idx][15:8] : flash_mem[word_idx][7:0]};
        end else begin
          rd_data_o <= flash_mem[word_idx][15:0];
        end
      end else if (take && q_req.op == PFW_OP_READ_HIGH) begin
        rd_data_o <= {8'h00, (q_req.byte_mode && q_req.ea[0]) ? 8'h00 : flash_mem[word_idx][23:16]};
      end
    end
  end

  // serial port: two lines, data never driven by this path
  assign prog_data_line_o    = 1'b0;
  assign prog_data_line_oe_o = 1'b0;

  logic unused_lines;
  assign unused_lines = prog_clock_line_i ^ prog_data_line_i;
endmodule
`default_nettype wire

// *** pfw_defs.svh ***
// constants for the program flash self-write path
`ifndef PFW_DEFS_SVH
`define PFW_DEFS_SVH

`define PFW_ADDR_W        24
`define PFW_EA_W          16
`define PFW_PAGE_W        8
`define PFW_WORD_W        24
`define PFW_LOW_W         16
`define PFW_HIGH_W        8
`define PFW_ROW_WORDS     32
`define PFW_ROW_BYTES     96
`define PFW_PANEL_ROWS    128
`define PFW_PANEL_WORDS   4096
`define PFW_MEM_WORDS     8192
`define PFW_WR_CYCLES     2
`define PFW_KEY_FIRST     8'h55
`define PFW_KEY_SECOND    8'haa
`define PFW_CLK_MHZ       25
`define PFW_OP_TIME_US    2000
`define PFW_OP_CYCLES     (`PFW_OP_TIME_US * `PFW_CLK_MHZ)
`define PFW_FIFO_DEPTH    32
`define PFW_ERASED_WORD   24'hffffff

`endif

// *** pfw_pkg.sv ***
// types for the program flash self-write path
`default_nettype none
package pfw_pkg;

  typedef enum logic [2:0] {
    PFW_OP_READ_LOW   = 3'h0,
    PFW_OP_READ_HIGH  = 3'h1,
    PFW_OP_WRITE_LOW  = 3'h2,
    PFW_OP_WRITE_HIGH = 3'h3,
    PFW_OP_KEY        = 3'h4,
    PFW_OP_START      = 3'h5,
    PFW_OP_SET_ADDR   = 3'h6
  } pfw_op_t;

  // one table operation as issued by the core
  typedef struct packed {
    pfw_op_t      op;
    logic         byte_mode;
    logic [7:0]   page;
    logic [15:0]  ea;
    logic [15:0]  data;
    logic         erase;
  } pfw_req_t;

  typedef enum logic [1:0] {
    PFW_ST_IDLE = 2'b00,
    PFW_ST_WAIT = 2'b01,
    PFW_ST_BUSY = 2'b10
  } pfw_state_t;

endpackage
`default_nettype wire

// *** pfw_fifo.sv ***
// request fifo in front of the self-write path
`timescale 1ns/100ps
`default_nettype none
module pfw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** pfw_core_asserts.sv ***
// concurrent checks on the self-write path ports
`timescale 1ns/100ps
`default_nettype none
module pfw_chk #(
  parameter int OP_CYCLES = 40
) (
  // watched ports
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        rd_valid_o,
  input wire logic [15:0] rd_data_o,
  input wire logic        core_stall_o,
  input wire logic        write_start_o,
  input wire logic [23:0] flash_address_o,
  input wire logic        key_unlocked_o,
  input wire logic        prog_data_line_o,
  input wire logic        prog_data_line_oe_o
);
  // ----------------
  // stall length and unlock history
  // ----------------
  int   cnt;
  logic seen;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) cnt <= 0;
    else cnt <= core_stall_o ? cnt + 1 : 0;
  end
  // cleared at op end so a stale unlock cannot excuse a later start
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) seen <= 1'b0;
    else if (key_unlocked_o) seen <= 1'b1;
    else if ($fell(core_stall_o)) seen <= 1'b0;
  end
  stall_len_a: assert property ($fell(core_stall_o) |-> cnt == OP_CYCLES) else $error("stall length wrong");
  stall_max_a: assert property (cnt <= OP_CYCLES) else $error("stall too long");
  start_eq_a: assert property (write_start_o == core_stall_o) else $error("start bit differs");
  rd_hold_a: assert property (!rd_valid_o |-> $stable(rd_data_o)) else $error("read data moved");
  prog_idle_a: assert property (!prog_data_line_oe_o && !prog_data_line_o) else $error("prog line driven");
  unlock_first_a: assert property ($rose(core_stall_o) |-> seen || key_unlocked_o) else $error("start unlocked");
  busy_no_rd_a: assert property (core_stall_o |-> !rd_valid_o) else $error("read while busy");
  busy_addr_a: assert property (core_stall_o && $past(core_stall_o) |-> $stable(flash_address_o))
    else $error("row address moved");
  busy_locked_a: assert property (core_stall_o && $past(core_stall_o) |-> !key_unlocked_o)
    else $error("unlock survived");
endmodule
bind pfw_core pfw_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
  .core_stall_o(core_stall_o), .write_start_o(write_start_o), .flash_address_o(flash_address_o),
  .key_unlocked_o(key_unlocked_o), .prog_data_line_o(prog_data_line_o),
  .prog_data_line_oe_o(prog_data_line_oe_o));
`default_nettype wire

// *** pfw_cpu_model.sv ***
// processor core model issuing table operations
`timescale 1ns/100ps
`default_nettype none
module pfw_cpu_model (
  // handshake
  input  wire logic              core_clk_i,
  input  wire logic              req_ready_i,
  output var logic               req_valid_o,
  output var pfw_pkg::pfw_req_t  req_o
);
  import pfw_pkg::*;
  // ----------------
  // request driver
  // ----------------
  logic [7:0] page;
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
    page = 8'h00;
  end
  // software reloads the page whenever the 16-bit effective address wraps
  task automatic set_page(input logic [7:0] p);
    page = p;
  endtask
  task automatic issue(input pfw_op_t op, input logic [15:0] ea, input logic [15:0] d, input logic bm, input logic er);
    @(posedge core_clk_i);
    req_valid_o <= 1'b1;
    req_o <= '{op, bm, page, ea, d, er};
    @(posedge core_clk_i);
    while (req_ready_i !== 1'b1) @(posedge core_clk_i);
    req_valid_o <= 1'b0;
    // released fields must not look still valid
    req_o <= pfw_req_t'(~req_o);
  endtask
  task automatic fill_row(input logic [15:0] base, input logic [23:0] seed);
    for (int i = 0; i < 32; i++) begin
      issue(PFW_OP_WRITE_LOW, base + 16'(2 * i), seed[15:0] + 16'(i), 1'b0, 1'b0);
      issue(PFW_OP_WRITE_HIGH, base + 16'(2 * i), {8'h00, seed[23:16] + 8'(i)}, 1'b0, 1'b0);
    end
  endtask
  task automatic commit(input logic er);
    issue(PFW_OP_KEY, 16'h0000, 16'h0055, 1'b0, 1'b0);
    issue(PFW_OP_KEY, 16'h0000, 16'h00aa, 1'b0, 1'b0);
    issue(PFW_OP_START, 16'h0000, 16'h0000, 1'b0, er);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the self-write path
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pfw_pkg::*;
  typedef struct packed {pfw_op_t op; logic [15:0] ea; logic [15:0] exp;} pfw_row_t;
  // long enough to fill the fifo while busy
  localparam int OPC = 100;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        req_valid, req_ready, rd_valid, stall, wstart, unlocked, pd_o, pd_oe;
  logic [15:0] rd_data;
  logic [23:0] faddr;
  pfw_req_t    req;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n;
  pfw_row_t    rows [4] = '{'{PFW_OP_READ_LOW, 16'h0040, 16'hc300}, '{PFW_OP_READ_HIGH, 16'h0040, 16'h005a},
                            '{PFW_OP_READ_LOW, 16'h007e, 16'h121f}, '{PFW_OP_READ_HIGH, 16'h0062, 16'h006b}};
  always #20 core_clk_i = ~core_clk_i;
  pfw_core #(.OP_CYCLES(OPC)) dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid), .req_ready_o(req_ready),
    .req_i(req), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .core_stall_o(stall), .write_start_o(wstart),
    .flash_address_o(faddr), .key_unlocked_o(unlocked), .prog_clock_line_i(1'b0), .prog_data_line_i(1'b0),
    .prog_data_line_o(pd_o), .prog_data_line_oe_o(pd_oe));
  pfw_cpu_model m (.core_clk_i(core_clk_i), .req_ready_i(req_ready), .req_valid_o(req_valid), .req_o(req));
  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input pfw_op_t op, input logic [15:0] ea, input logic [15:0] exp);
    m.issue(op, ea, 16'h0000, 1'b0, 1'b0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      n++;
    end
    check(24'(rd_data & (op == PFW_OP_READ_HIGH ? 16'h00ff : 16'hffff)), 24'(exp));
    check(faddr, {8'h00, ea});
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    check(24'({req_ready, stall, rd_valid, unlocked, pd_oe, pd_o}), 24'h000020);
    check(faddr, 24'h000000);
    m.fill_row(16'h0040, 24'h5a1200);
    m.issue(PFW_OP_WRITE_LOW, 16'h0041, 16'hc3c3, 1'b1, 1'b0);
    m.commit(1'b0);
    for (int i = 0; i < 32; i++) m.issue(PFW_OP_READ_LOW, 16'h0046, 16'h0000, 1'b0, 1'b0);
    // the last push lands at this edge; look once the fifo pointers have settled
    @(negedge core_clk_i);
    check(24'({req_ready, stall, wstart}), 24'h000003);
    n = 0;
    repeat (300) begin
      @(posedge core_clk_i);
      if (rd_valid === 1'b1) begin
        n++;
        check(24'(rd_data), 24'h001203);
      end
    end
    check(24'(n), 24'h000020);
    foreach (rows[i]) rd(rows[i].op, rows[i].ea, rows[i].exp);
    m.issue(PFW_OP_START, 16'h0000, 16'h0000, 1'b0, 1'b0);
    repeat (6) @(posedge core_clk_i);
    check(24'(stall), 24'h000000);
    m.issue(PFW_OP_WRITE_LOW, 16'h0042, 16'h0bad, 1'b0, 1'b0);
    rd(PFW_OP_READ_LOW, 16'h0042, 16'h1201);
    m.issue(PFW_OP_SET_ADDR, 16'h0044, 16'h0000, 1'b0, 1'b0);
    m.commit(1'b1);
    rd(PFW_OP_READ_LOW, 16'h0044, 16'hffff);
    rd(PFW_OP_READ_HIGH, 16'h007e, 16'h00ff);
    // page bits must reach the captured address above the effective address
    m.set_page(8'h01);
    m.issue(PFW_OP_SET_ADDR, 16'h0046, 16'h0000, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk_i);
    check(faddr, 24'h010046);
    end_sim();
  end
endmodule
`default_nettype wire
